// ==== inc/dsc_pkg.sv ====
package dsc_pkg;
  // Register map, byte addresses on the control port
  localparam int          ADDR_W              = 13;
  localparam int          DATA_W              = 8;
  localparam logic [12:0] ADDR_TP4_HIGH       = 13'h0020;
  localparam logic [12:0] ADDR_SYNC_CTRL      = 13'h003A;
  localparam logic [7:0]  RST_TP4_HIGH        = 8'h00;
  localparam logic [7:0]  RST_SYNC_CTRL       = 8'h00;
  // Sync-control field positions
  localparam int          BIT_MASTER_EN       = 0;
  localparam int          BIT_DIV_SYNC_EN     = 1;
  localparam int          BIT_NEXT_SYNC_ONLY  = 2;
  localparam logic [7:0]  SYNC_CTRL_WR_MASK   = 8'h07;
  // Divider defaults
  localparam int          DIV_W               = 4;
  localparam logic [3:0]  DIV_RATIO_DEF       = 4'h1;
  localparam logic [3:0]  DIV_ZERO            = 4'h0;
  localparam logic [7:0]  RD_ZERO             = 8'h00;
endpackage : dsc_pkg

// ==== design/dsc_top.sv ====
`timescale 1ns/1ns
module dsc_top
  import dsc_pkg::*;
#(
  parameter logic [DIV_W-1:0] DIV_RATIO = DIV_RATIO_DEF
) (
  input  wire logic              CLOCK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  input  wire logic [ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [DATA_W-1:0] REG_WDATA_I,
  output logic      [DATA_W-1:0] REG_RDATA_O,
  input  wire logic              SYNC_I,
  output logic                   SYNC_BUF_EN_O,
  output logic                   DIV_ALIGN_O,
  output logic                   DIV_CLK_O,
  output logic      [DATA_W-1:0] TP4_HIGH_O
);

  // Stored registers and their next values
  logic [DATA_W-1:0] tp4_high_q;
  logic [DATA_W-1:0] tp4_high_d;
  logic [DATA_W-1:0] sync_ctrl_q;
  logic [DATA_W-1:0] sync_ctrl_d;
  logic [DATA_W-1:0] rdata_d;

  // Sync path
  logic              sync_prev_q;
  logic              sync_prev_d;
  logic              sync_rise;
  logic              master_en;
  logic              div_sync_en;
  logic              one_shot;
  logic              gate_open;
  logic              align_hit;
  logic              one_shot_done;

  // Divider
  logic [DIV_W-1:0]  div_cnt_q;
  logic [DIV_W-1:0]  div_cnt_d;
  logic              div_clk_q;
  logic              div_clk_d;
  logic              div_wrap;

  // Control port decode
  logic              wr_tp4_hit;
  logic              wr_ctl_hit;
  logic              rd_tp4_hit;
  logic              rd_ctl_hit;
  logic [DATA_W-1:0] ctl_wr_val;

  // Address decode; a write to any other address touches nothing, a read there loads zero read data
  assign wr_tp4_hit = REG_WR_I & (REG_ADDR_I == ADDR_TP4_HIGH);
  assign wr_ctl_hit = REG_WR_I & (REG_ADDR_I == ADDR_SYNC_CTRL);
  assign rd_tp4_hit = REG_RD_I & (REG_ADDR_I == ADDR_TP4_HIGH);
  assign rd_ctl_hit = REG_RD_I & (REG_ADDR_I == ADDR_SYNC_CTRL);

  // Reserved bits dropped at the door so they can never act
  assign ctl_wr_val = REG_WDATA_I & SYNC_CTRL_WR_MASK;

  // Field decode of the control register
  assign master_en   = sync_ctrl_q[BIT_MASTER_EN];
  assign div_sync_en = sync_ctrl_q[BIT_DIV_SYNC_EN];
  assign one_shot    = sync_ctrl_q[BIT_NEXT_SYNC_ONLY];

  // Gate between the sync input and the divider
  assign gate_open = master_en & div_sync_en;

  // Edge of the sync input; the input is taken as synchronous here
  assign sync_rise = SYNC_I & ~sync_prev_q & master_en;

  // Every gated pulse aligns; one-shot stops after the first via bit 1
  assign align_hit = sync_rise & gate_open;

  // One-shot alignment done; drops the gate bit on the same edge
  assign one_shot_done = align_hit & one_shot;

  // Divider wrap at the end of a half period
  assign div_wrap = (div_cnt_q == DIV_RATIO - 1'b1);

  // Edge detector next value; held low while bit 0 is clear
  // Limitation: a sync input already high when bit 0 rises counts as an edge
  always_comb begin
    sync_prev_d = 1'b0;
    if (master_en) begin
      sync_prev_d = SYNC_I;
    end
  end

  // Edge detector storage; reset to the idle level of the pin
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      sync_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_prev_d;
    end
  end

  // Test pattern four high byte next value
  always_comb begin
    tp4_high_d = tp4_high_q;
    if (wr_tp4_hit) begin
      tp4_high_d = REG_WDATA_I;
    end
  end

  // Test pattern four high byte, plain storage
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      tp4_high_q <= RST_TP4_HIGH;
    end else begin
      tp4_high_q <= tp4_high_d;
    end
  end

  // Sync control next value
  // Self-clear wins over a same-cycle host write of bit 1, so a
  // completed one-shot can never be silently re-armed by a racing write
  always_comb begin
    sync_ctrl_d = sync_ctrl_q;
    if (wr_ctl_hit) begin
      sync_ctrl_d = ctl_wr_val;
    end
    if (one_shot_done) begin
      sync_ctrl_d[BIT_DIV_SYNC_EN] = 1'b0;
    end
  end

  // Sync control storage
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      sync_ctrl_q <= RST_SYNC_CTRL;
    end else begin
      sync_ctrl_q <= sync_ctrl_d;
    end
  end

  // Divider next value; an align restarts the count and the phase
  always_comb begin
    div_cnt_d = div_cnt_q + 1'b1;
    div_clk_d = div_clk_q;
    if (align_hit) begin
      div_cnt_d = DIV_ZERO;
      div_clk_d = 1'b0;
    end else if (div_wrap) begin
      div_cnt_d = DIV_ZERO;
      div_clk_d = ~div_clk_q;
    end
  end

  // Divider count
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      div_cnt_q <= DIV_ZERO;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  // Divider phase
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      div_clk_q <= 1'b0;
    end else begin
      div_clk_q <= div_clk_d;
    end
  end

  // Read data next value; holds between reads, unmapped reads give zero
  always_comb begin
    rdata_d = REG_RDATA_O;
    if (rd_tp4_hit) begin
      rdata_d = tp4_high_q;
    end else if (rd_ctl_hit) begin
      rdata_d = sync_ctrl_q & SYNC_CTRL_WR_MASK;
    end else if (REG_RD_I) begin
      rdata_d = RD_ZERO;
    end
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= RD_ZERO;
    end else begin
      REG_RDATA_O <= rdata_d;
    end
  end

  // Buffer power enable, one cycle behind bit 0
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      SYNC_BUF_EN_O <= 1'b0;
    end else begin
      SYNC_BUF_EN_O <= master_en;
    end
  end

  // Align pulse, one cycle long
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      DIV_ALIGN_O <= 1'b0;
    end else begin
      DIV_ALIGN_O <= align_hit;
    end
  end

  // Divided clock; retimed so the pin comes straight from a flop
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      DIV_CLK_O <= 1'b0;
    end else begin
      DIV_CLK_O <= div_clk_q;
    end
  end

  // Pattern byte copy for the pattern generator
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      TP4_HIGH_O <= RST_TP4_HIGH;
    end else begin
      TP4_HIGH_O <= tp4_high_q;
    end
  end

endmodule : dsc_top

// ==== bench/dsc_host.sv ====
`timescale 1ns/1ns
// Host on the control port, one access at a time
module dsc_host import dsc_pkg::*; (
  input  wire logic              clk_i,
  output logic                   wr_o,
  output logic                   rd_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o
);
  // Port idle between accesses, address zero never used
  initial {wr_o, rd_o, addr_o, wdata_o} = '0;
  // Strobe for one cycle, then an idle cycle so read data has landed
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
    @(posedge clk_i);
    {wr_o, rd_o} <= 2'h0;
    @(posedge clk_i);
  endtask : acc
endmodule : dsc_host

// ==== bench/dsc_top_sva.sv ====
`timescale 1ns/1ns
// Port checks; one-shot state is judged by the bench readback
module dsc_chk import dsc_pkg::*; (
  input wire logic              CLOCK_I, SYS_RST_I, REG_WR_I, REG_RD_I, SYNC_I, SYNC_BUF_EN_O, DIV_ALIGN_O,
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic [DATA_W-1:0] REG_WDATA_I, REG_RDATA_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  // Control write clearing one bit, then a quiet cycle
  sequence ctl_wr(int b);
    REG_WR_I && REG_ADDR_I == ADDR_SYNC_CTRL && !REG_WDATA_I[b] ##1 !REG_WR_I;
  endsequence
  buf_off_a: assert property (ctl_wr(0) |=> !SYNC_BUF_EN_O && !DIV_ALIGN_O) else $error("sync active after off");
  gate_off_a: assert property (ctl_wr(1) |=> !DIV_ALIGN_O) else $error("align with gate shut");
  align_buf_a: assert property (DIV_ALIGN_O |-> SYNC_BUF_EN_O) else $error("align without buffer");
  align_one_a: assert property (DIV_ALIGN_O |=> !DIV_ALIGN_O) else $error("align pulse too long");
  align_src_a: assert property (DIV_ALIGN_O |-> $past(SYNC_I)) else $error("align without sync");
  rsvd_zero_a: assert property (REG_RD_I && REG_ADDR_I == ADDR_SYNC_CTRL |=> REG_RDATA_O[7:3] == 5'h00)
    else $error("reserved bits not zero");
endmodule : dsc_chk
bind dsc_top dsc_chk i_dsc_chk (.*);

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top import dsc_pkg::*; ;
  logic              clk = 0, rst = 1, sync = 0, wr, rd, buf_en, align, dclk;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wd, rdata, tp4, v;
  logic [7:0]        modes [6] = '{8'h07, 8'h05, 8'h02, 8'h03, 8'h07, 8'h00};
  int n_fail = 0, cmp_count = 0, n_al = 0, m_al = 0, cyc = 0, seed = 11527, m_ctl = 0, m_tp = 0;
  always #20 clk = !clk;
  dsc_top i_dsc_top (.CLOCK_I(clk), .SYS_RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
    .REG_WDATA_I(wd), .REG_RDATA_O(rdata), .SYNC_I(sync), .SYNC_BUF_EN_O(buf_en), .DIV_ALIGN_O(align),
    .DIV_CLK_O(dclk), .TP4_HIGH_O(tp4));
  dsc_host i_dsc_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));
  // Count align pulses; a hang is cut at a fixed ceiling
  always @(posedge clk) begin
    n_al <= n_al + (align === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Model keeps only the writable bits
  task automatic wrm(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    i_dsc_host.acc(1'b1, a, d);
    if (a == ADDR_SYNC_CTRL) m_ctl = d & 8'h07;
    if (a == ADDR_TP4_HIGH) m_tp = d;
  endtask : wrm
  task automatic rdc(input logic [ADDR_W-1:0] a, input int exp);
    i_dsc_host.acc(1'b0, a, 8'h00);
    chk(rdata, exp[7:0]);
  endtask : rdc
  // One sync pulse; one-shot drops the gate once taken
  task automatic pulse;
    @(posedge clk) sync <= 1'b1;
    repeat (2) @(posedge clk);
    sync <= 1'b0;
    @(negedge clk);
    if ((m_ctl & 3) == 3) chk({7'h00, dclk}, 8'h00);
    repeat (4) @(posedge clk);
    if ((m_ctl & 3) == 3) m_al++;
    if ((m_ctl & 7) == 7) m_ctl = 5;
  endtask : pulse
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(ADDR_SYNC_CTRL, 0);
    wrm(ADDR_TP4_HIGH, 8'($random(seed)));
    rdc(ADDR_TP4_HIGH, m_tp);
    chk(tp4, m_tp[7:0]);
    wrm(13'h0015, 8'hFF);
    rdc(13'h0015, 0);
    // Divider free-runs at the default ratio, toggling every cycle
    @(negedge clk) v = {7'h00, dclk};
    @(negedge clk) chk({7'h00, dclk}, v ^ 8'h01);
    $display("register tests done");
    // Random reserved bits ride on each mode
    foreach (modes[i]) begin
      v = modes[i];
      wrm(ADDR_SYNC_CTRL, v | (8'($random(seed)) & 8'hF8));
      pulse();
      pulse();
      rdc(ADDR_SYNC_CTRL, m_ctl);
      chk(8'(n_al), 8'(m_al));
      $display("mode %h done", v);
    end
    give_verdict();
  end
endmodule : tb_top
